// File: rtl/dtm_pkg.sv
// package for the transfer-mode decode and cycle sequencer
package dtm_pkg;
  localparam int unsigned MODE_W = 3;
  localparam int unsigned COUNT_W = 10;
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned COUNT_LSB = 4;
  localparam int unsigned CTRL_W = 14;
  localparam logic [MODE_W-1:0] MODE_STOP = 3'h0;
  localparam logic [MODE_W-1:0] MODE_BASIC = 3'h1;
  localparam logic [MODE_W-1:0] MODE_AUTO = 3'h2;
  localparam logic [MODE_W-1:0] MODE_PINGPONG = 3'h3;
  localparam logic [MODE_W-1:0] MODE_MEM_SG = 3'h4;
  localparam logic [MODE_W-1:0] MODE_MEM_SG_ALT = 3'h5;
  localparam logic [MODE_W-1:0] MODE_PER_SG = 3'h6;
  localparam logic [MODE_W-1:0] MODE_PER_SG_ALT = 3'h7;

  // control word fields as read from system memory
  typedef struct packed {
    logic [COUNT_W-1:0] item_count_minus_one;
    logic [MODE_W-1:0] cycle_mode_field;
  } dtm_ctrl_s;

  // one item move handed to the datapath
  typedef struct packed {
    logic alt;
    logic [COUNT_W-1:0] remaining;
  } dtm_item_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_WAIT_REQ,
    ST_MOVE,
    ST_WRITEBACK
  } dtm_state_e;
endpackage

// File: rtl/dtm_sequencer.sv
// transfer-mode decode and cycle sequencing for one channel
//
// Contract
// [R01] mode comes from a 3-bit field; zero means stopped or invalid
// [R02] host clears the mode field before enabling the channel
// [R03] basic mode needs a new request before every item arbitration
// [R04] auto-request: one request moves the whole programmed count
// [R05] ping-pong runs primary then alternate structure, alternating
// [R06] ping-pong continues until invalid structure or mode set basic/auto
// [R07] host refreshes a finished structure before the device returns to it
// [R08] memory scatter-gather: 0x4 primary only, 0x5 alternate only
// [R09] peripheral scatter-gather: 0x6 primary only, 0x7 alternate only
// [R10] item count field holds items minus one, zero meaning one item
//
// ****************************************
// overview
// ****************************************
// one channel, one item in flight at a time
// idle -> fetch structure -> wait request -> move item -> ... -> write back
// mode is relatched on every fetch, so a host rewrite of the mode
// takes effect at the next structure read, never inside a cycle
// basic mode re-arbitrates on each item and needs req each time
// every mode other than basic (auto, ping-pong, scatter-gather) needs req for the first item of a structure only
// ping-pong flips between primary and alternate after each write back
// every run starts from the primary structure, unless the last one was disabled while waiting for a request
// refused structures (stop code, misplaced sg code) end the run at once
// limitation: item_ack must not come before item_go; no timeout is kept
// trade-off: writeback_word is a constant stop word, so a finished
// structure never reruns even if the host forgets to refresh it
module dtm_sequencer
  import dtm_pkg::*;
#(
  parameter int unsigned ITEM_COUNT_BITS = COUNT_W,
  parameter int unsigned MODE_BITS = MODE_W
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic req,
  input wire logic ctrl_valid,
  input wire dtm_ctrl_s ctrl_word,
  input wire logic item_ack,
  output logic ctrl_fetch,
  output logic ctrl_sel_alt,
  output logic item_go,
  output dtm_item_s item,
  output logic writeback,
  output dtm_ctrl_s writeback_word,
  output logic cycle_done,
  output logic stopped,
  output logic sg_misplaced
);

  // ****************************************
  // state and decode
  // ****************************************
  dtm_state_e state;
  logic [MODE_W-1:0] mode;
  logic [COUNT_W-1:0] remaining;
  logic use_alt;
  logic started;

  // ****************************************
  // elaboration checks
  // ****************************************
  // the control word layout is fixed by the package struct
  if (ITEM_COUNT_BITS != COUNT_W) begin : g_bad_count
    $error("item count width must match the control word");
  end
  if (MODE_BITS != MODE_W) begin : g_bad_mode
    $error("mode field width must match the control word");
  end

  // ****************************************
  // decode
  // ****************************************
  wire [MODE_W-1:0] fetched_mode = ctrl_word.cycle_mode_field; // [R01]
  wire fetched_stop = (fetched_mode == MODE_STOP); // [R01]
  wire is_basic = (mode == MODE_BASIC);
  wire is_auto = (mode == MODE_AUTO);
  wire is_pp = (mode == MODE_PINGPONG);
  // alt-only codes in primary or primary-only codes in alternate
  wire primary_only_code = (fetched_mode == MODE_MEM_SG) || (fetched_mode == MODE_PER_SG);
  wire alt_only_code = (fetched_mode == MODE_MEM_SG_ALT) || (fetched_mode == MODE_PER_SG_ALT);
  wire misplaced = (primary_only_code && use_alt) || (alt_only_code && !use_alt); // [R08] [R09]
  // basic needs a request every item, auto only the first one
  wire req_ok = is_basic ? req : (started ? 1'b1 : req); // [R03] [R04]
  wire last_item = (remaining == '0); // [R10]
  wire next_use_alt = is_pp ? !use_alt : use_alt; // [R05]

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      mode <= MODE_STOP;
      remaining <= '0;
      use_alt <= 1'b0;
      started <= 1'b0;
      ctrl_fetch <= 1'b0;
      item_go <= 1'b0;
      writeback <= 1'b0;
      cycle_done <= 1'b0;
      stopped <= 1'b1;
      sg_misplaced <= 1'b0;
    end else begin
      ctrl_fetch <= 1'b0;
      item_go <= 1'b0;
      writeback <= 1'b0;
      cycle_done <= 1'b0;
      sg_misplaced <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (enable && req) begin
            ctrl_fetch <= 1'b1;
            stopped <= 1'b0;
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (ctrl_valid) begin
            mode <= fetched_mode;
            remaining <= ctrl_word.item_count_minus_one; // [R10]
            started <= 1'b0;
            sg_misplaced <= misplaced;
            if (fetched_stop || misplaced || !enable) begin // [R01] [R06]
              stopped <= 1'b1;
              use_alt <= 1'b0;
              state <= ST_IDLE;
            end else begin
              state <= ST_WAIT_REQ;
            end
          end
        end
        ST_WAIT_REQ: begin
          if (!enable) begin
            stopped <= 1'b1;
            state <= ST_IDLE;
          end else if (req_ok) begin // [R03] [R04]
            item_go <= 1'b1;
            started <= 1'b1;
            state <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          if (item_ack) begin
            if (last_item) begin
              writeback <= 1'b1;
              state <= ST_WRITEBACK;
            end else begin
              remaining <= remaining - 1'b1;
              state <= ST_WAIT_REQ;
            end
          end
        end
        ST_WRITEBACK: begin
          cycle_done <= 1'b1;
          use_alt <= next_use_alt; // [R05]
          if (is_pp && enable) begin // [R06]
            ctrl_fetch <= 1'b1;
            state <= ST_FETCH;
          end else begin
            // back to primary so the next run does not start on the alternate
            use_alt <= 1'b0; // [R05]
            stopped <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // outputs held in flops
  // ****************************************
  // structure select runs one step ahead at write back so the
  // fetch raised at that edge already points at the other structure
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_sel_alt <= 1'b0;
    end else begin
      ctrl_sel_alt <= (state == ST_WRITEBACK) ? next_use_alt : use_alt; // [R05]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      item <= '0;
    end else begin
      item.alt <= use_alt;
      item.remaining <= remaining; // [R10]
    end
  end

  // finished structure marked stopped so a stale one is never rerun
  always_ff @(posedge clk) begin
    if (rst) begin
      writeback_word <= '0;
    end else begin
      writeback_word.cycle_mode_field <= MODE_STOP; // [R06]
      writeback_word.item_count_minus_one <= '0;
    end
  end

  wire unused_auto = is_auto;
endmodule

// File: tb/dtm_host.sv
// host memory and datapath model
module dtm_host
  import dtm_pkg::*;
(
  input wire logic clk,
  input wire logic ctrl_fetch,
  input wire logic ctrl_sel_alt,
  input wire logic item_go,
  input wire dtm_ctrl_s prim,
  input wire dtm_ctrl_s alt,
  output logic ctrl_valid = 1'b0,
  output dtm_ctrl_s ctrl_word = '0,
  output logic item_ack = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // released bus flips to its own inverse every cycle, so stale data never holds still
  always @(posedge clk) begin
    ctrl_valid <= ctrl_fetch;
    ctrl_word <= ctrl_fetch ? (ctrl_sel_alt ? alt : prim) : ~ctrl_word;
    item_ack <= item_go;
  end
endmodule

// File: tb/dtm_sequencer_chk.sv
// assertions for the sequencer
module dtm_sequencer_chk
  import dtm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic ctrl_valid,
  input wire dtm_ctrl_s ctrl_word,
  input wire logic item_ack,
  input wire logic ctrl_fetch,
  input wire logic ctrl_sel_alt,
  input wire logic item_go,
  input wire logic cycle_done,
  input wire logic sg_misplaced
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [2:0] m;
  logic sa;
  logic [10:0] n;
  logic [10:0] k;
  always_ff @(posedge clk) begin
    k <= ctrl_valid ? 11'h0 : k + 11'(item_go);
    if (ctrl_valid) begin
      m <= ctrl_word.cycle_mode_field;
      sa <= ctrl_sel_alt;
      n <= 11'(ctrl_word.item_count_minus_one);
    end
  end
  property p_stop; ctrl_valid && ctrl_word.cycle_mode_field == MODE_STOP |=> !item_go [*4]; endproperty
  a_stop: assert property (p_stop) else $error("item after stop word");
  property p_basic; item_go && m == MODE_BASIC |-> $past(req); endproperty
  a_basic: assert property (p_basic) else $error("basic item without request");
  property p_auto; item_ack && m == MODE_AUTO && k <= n |-> ##[1:3] item_go; endproperty
  a_auto: assert property (p_auto) else $error("auto item missing");
  property p_pp; cycle_done && m == MODE_PINGPONG |-> ##[0:1] (ctrl_fetch && ctrl_sel_alt != sa); endproperty
  a_pp: assert property (p_pp) else $error("no alternation");
  property p_cnt; cycle_done |-> k == n + 11'h1; endproperty
  a_cnt: assert property (p_cnt) else $error("wrong item count");
  property p_sg; ctrl_valid && !ctrl_sel_alt && ctrl_word.cycle_mode_field[0] && ctrl_word.cycle_mode_field[2] |-> ##[1:2] sg_misplaced; endproperty
  a_sg: assert property (p_sg) else $error("misplaced code missed");
  c_done: cover property (cycle_done);
  c_alt: cover property (ctrl_fetch && ctrl_sel_alt);
  c_sg: cover property (sg_misplaced);
endmodule
bind dtm_sequencer dtm_sequencer_chk chk (.clk, .rst, .req, .ctrl_valid, .ctrl_word, .item_ack,
  .ctrl_fetch, .ctrl_sel_alt, .item_go, .cycle_done, .sg_misplaced);

// File: tb/dtm_sequencer_bench.sv
// bench for the sequencer
module dtm_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dtm_pkg::*;
  logic clk = 0, rst = 1, enable = 0, req = 0, ctrl_valid, item_ack, ctrl_fetch, ctrl_sel_alt;
  logic item_go, writeback, cycle_done, stopped, sg_misplaced;
  dtm_ctrl_s ctrl_word, writeback_word, prim = '0, alt = '0;
  dtm_item_s item;
  int failures = 0, n_tests = 0, gos = 0, fa = 0, mis = 0, dones = 0, wbs = 0;
  always #2 clk = ~clk;
  dtm_sequencer dut (.clk, .rst, .enable, .req, .ctrl_valid, .ctrl_word, .item_ack, .ctrl_fetch,
    .ctrl_sel_alt, .item_go, .item, .writeback, .writeback_word, .cycle_done, .stopped, .sg_misplaced);
  dtm_host host (.clk, .ctrl_fetch, .ctrl_sel_alt, .item_go, .prim, .alt, .ctrl_valid, .ctrl_word,
    .item_ack);
  always @(posedge clk) begin
    gos += item_go;
    fa += ctrl_fetch & ctrl_sel_alt;
    mis += sg_misplaced;
    dones += cycle_done;
    wbs += writeback;
  end
  task chk(input logic [10:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  // request stays up only until the wanted number of items went out
  task go(input dtm_ctrl_s p, a, input int t);
    prim = p;
    alt = a;
    repeat (40) @(negedge clk) req = gos < t;
  endtask
  task t_basic;
    gos = 0;
    go('{10'h1, MODE_BASIC}, '0, 1);
    chk(gos, 1);
    go('{10'h1, MODE_BASIC}, '0, 2);
    chk(gos, 2);
    chk(stopped, 1);
    chk(item, 0);
    chk(writeback_word.cycle_mode_field, MODE_STOP);
    $display("basic end");
  endtask
  task t_auto;
    gos = 0;
    go('{10'h2, MODE_AUTO}, '0, 1);
    chk(gos, 3);
    $display("auto end");
  endtask
  task t_pp;
    gos = 0;
    fa = 0;
    dones = 0;
    wbs = 0;
    go('{10'h0, MODE_PINGPONG}, '{10'h0, MODE_AUTO}, 2);
    chk(gos, 2);
    chk(fa, 1);
    chk(dones, 2);
    chk(wbs, 2);
    chk(item.alt, 0);
    $display("pingpong end");
  endtask
  task t_sg;
    gos = 0;
    mis = 0;
    go('{10'h0, MODE_MEM_SG_ALT}, '0, 1);
    chk(mis != 0, 1);
    mis = 0;
    go('{10'h0, MODE_PER_SG_ALT}, '0, 1);
    chk(mis != 0, 1);
    go('{10'h0, MODE_MEM_SG}, '0, 1);
    chk(gos, 1);
    go('{10'h0, MODE_PER_SG}, '0, 2);
    chk(gos, 2);
    gos = 0;
    go('0, '0, 1);
    chk(gos, 0);
    $display("refusal end");
  endtask
  task results;
    $display("compares %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 0;
    enable = 1;
    t_basic;
    t_auto;
    t_pp;
    t_sg;
    results;
  end
  initial begin
    #6000;
    failures++;
    results;
  end
endmodule
